// ==== dv/block_read_command_handler_tb.sv ====
// Self-checking bench for the block-interrupt read handler.
// Assumes the media model answers every media request.
`timescale 1ns/10ps
`default_nettype none
module block_read_command_handler_tb;
  import block_read_pkg::*;
  logic clock = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic media_valid, media_ready, media_req, irq;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, bad = 0;
  logic [47:0] media_lba;
  media_beat_t media_beat;
  int fails = 0, n_compared = 0;
  // Rows: address, expected byte, expected response.
  logic [15:0] rows [7] = '{{OFS_STAT_CMD, 8'h50, RESP_OKAY}, {OFS_DEVHEAD, DEVHEAD_RST, RESP_OKAY},
    {OFS_BLKSIZE, BLKSIZE_RST, RESP_OKAY}, {OFS_IRQ_MASK, 8'h00, RESP_OKAY}, {OFS_ERR_FEAT, 8'h00, RESP_OKAY},
    {6'h30, 8'h00, RESP_SLVERR}, {6'h02, 8'h00, RESP_SLVERR}};
  logic [13:0] set1 [8] = '{{OFS_BLKSIZE, 8'h02}, {OFS_SECCNT, 8'h02}, {OFS_SECNUM, 8'h05}, {OFS_CYLLO, 8'h00},
    {OFS_CYLHI, 8'h00}, {OFS_DEVHEAD, 8'he3}, {OFS_IRQ_MASK, 8'h03}, {OFS_STAT_CMD, OP_READ_MULT}};
  logic [13:0] set2 [9] = '{{OFS_SECCNT, 8'h00}, {OFS_SECCNT, 8'h01}, {OFS_SECNUM, 8'h44}, {OFS_SECNUM, 8'h11},
    {OFS_CYLLO, 8'h00}, {OFS_CYLLO, 8'h00}, {OFS_CYLHI, 8'h00}, {OFS_CYLHI, 8'h00}, {OFS_STAT_CMD, OP_READ_MULT_EXT}};
  block_read_cmd i_dut (.*);
  media_model i_media (.*);
  // Free-running clock and a watchdog well beyond the expected run.
  initial forever #20 clock = ~clock;
  initial begin
    #2400000;
    fails++;
    summarize();
  end
  task automatic summarize;
    $display("counts: %0d compared, %0d failed", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Handshakes are sampled at the falling edge, half a cycle before the rising edge, when inputs are settled.
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic ha, hw, hb;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clock);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      @(posedge clock);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [5:0] a);
    logic ha, hr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge clock);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ha) s_axi_arvalid <= 1'b0;
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e, input string n);
    rd(a);
    chk(n, {24'h0, e}, d);
  endtask
  task automatic waitst(input logic [7:0] e);
    d = 'x;
    for (int i = 0; i < 200 && d !== {24'h0, e}; i++) rd(OFS_STAT_CMD);
    chk("status", {24'h0, e}, d);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 7; i++) begin
      rc(rows[i][15:10], rows[i][9:2], "reset value");
      chk("response", {30'h0, rows[i][1:0]}, {30'h0, r});
    end
    $display("test reset_values done");
    // Two sectors in one block: a single interrupt for both.
    for (int i = 0; i < 8; i++) wr(set1[i][13:8], set1[i][7:0]);
    waitst(8'h58);
    @(negedge clock);
    chk("lba", 32'h03000005, media_lba[31:0]);
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge clock);
    rc(OFS_IRQ_STAT, 8'h01, "block event");
    wr(OFS_IRQ_STAT, 8'h01);
    for (int i = 0; i < 512; i++) begin
      if (i == 256) rc(OFS_IRQ_STAT, 8'h00, "no sector event");
      rd(OFS_DATA);
      chk("word", {16'h0, 8'h05 + 8'(i / 256), 8'(i)}, d);
    end
    waitst(8'h50);
    rc(OFS_SECNUM, 8'h06, "last lba");
    rc(OFS_DEVHEAD, 8'he3, "head bits");
    $display("test block_read done");
    // Extended read hitting an uncorrectable sector.
    bad <= 2'b11;
    for (int i = 0; i < 9; i++) wr(set2[i][13:8], set2[i][7:0]);
    waitst(8'h51);
    rc(OFS_ERR_FEAT, 8'h40, "error code");
    rc(OFS_IRQ_STAT, 8'h02, "error event");
    rc(OFS_SECNUM, 8'h11, "low byte");
    wr(OFS_DEVCTL, 8'h80);
    rc(OFS_SECNUM, 8'h44, "high byte");
    wr(OFS_DEVCTL, 8'h00);
    wr(OFS_IRQ_STAT, 8'h02);
    @(negedge clock);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge clock);
    $display("test ext_error done");
    // Unknown opcode is ignored; zero block size aborts.
    bad <= 2'b00;
    wr(OFS_STAT_CMD, 8'h20);
    rc(OFS_ERR_FEAT, 8'h40, "ignored opcode");
    wr(OFS_BLKSIZE, 8'h00);
    wr(OFS_STAT_CMD, OP_READ_MULT);
    waitst(8'h51);
    rc(OFS_ERR_FEAT, 8'h04, "abort code");
    $display("test abort done");
    summarize();
  end
endmodule
`default_nettype wire

// ==== dv/media_model.sv ====
// Media engine stand-in: streams 16-bit words, word = {lba[7:0], index}.
// Assumes the handler's clock and its media handshake.
`timescale 1ns/10ps
`default_nettype none
module media_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic media_req,
  input wire logic media_ready,
  input wire logic [47:0] media_lba,
  input wire logic [1:0] bad,
  output var block_read_pkg::media_beat_t media_beat,
  output logic media_valid
);
  import block_read_pkg::*;
  logic [7:0] idx_q;
  logic [15:0] w;
  // The index restarts with every command so each word is predictable.
  always_ff @(posedge clock) begin
    if (!rst_n || !media_req) idx_q <= 8'h00;
    else if (media_valid && media_ready) idx_q <= idx_q + 8'h01;
  end
  assign w = {media_lba[7:0], idx_q};
  assign media_valid = media_req; // A word is on offer whenever media_req is high.
  // Idle lines show the inverse word, so a stale copy cannot pass.
  assign media_beat = media_valid ? {w, bad} : {~w, 2'b00};
endmodule
`default_nettype wire

// ==== shared/block_read_pkg.sv ====
// Shared constants and types for the block-interrupt read command handler.
// Assumes a single 25 MHz clock domain and a 32-bit AXI4-Lite register bus.
package block_read_pkg;
  // ----------------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ----------------------------------------------------------------------
  localparam int AXI_AW = 6;
  localparam logic [5:0] OFS_DATA = 6'h00;
  localparam logic [5:0] OFS_ERR_FEAT = 6'h04;
  localparam logic [5:0] OFS_SECCNT = 6'h08;
  localparam logic [5:0] OFS_SECNUM = 6'h0c;
  localparam logic [5:0] OFS_CYLLO = 6'h10;
  localparam logic [5:0] OFS_CYLHI = 6'h14;
  localparam logic [5:0] OFS_DEVHEAD = 6'h18;
  localparam logic [5:0] OFS_STAT_CMD = 6'h1c;
  localparam logic [5:0] OFS_DEVCTL = 6'h20;
  localparam logic [5:0] OFS_BLKSIZE = 6'h24;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h28;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h2c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Opcodes, field positions and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_READ_MULT = 8'hc4;
  localparam logic [7:0] OP_READ_MULT_EXT = 8'h29;
  localparam int ER_UNC = 6;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int HOB_BIT = 7;
  localparam int IRQ_BLOCK = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_W = 2;
  localparam int WORDS_PER_SECTOR = 256;
  localparam logic [7:0] DEVHEAD_RST = 8'ha0;
  localparam logic [7:0] BLKSIZE_RST = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [16:0] CNT_EXT_ZERO = 17'h10000;
  localparam logic [16:0] CNT_STD_ZERO = 17'h00100;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_FETCH = 2'b01,
    S_XFER = 2'b10
  } cmd_state_t;

  // One 16-bit word from the media side, or an error marker in its place.
  typedef struct packed {
    logic [15:0] word;
    logic err;
    logic uncorrectable_data_flag;
  } media_beat_t;

  // A task-file byte with its current and previous written value.
  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] prev;
  } tf_byte_t;
endpackage

// ==== verilog/block_read_cmd.sv ====
// Block-interrupt multi-sector read command handler with AXI4-Lite task file.
// Assumes a media engine on the same clock that streams 16-bit words.
//
// What this block does
// - Command write of C4h starts the 28-bit block-interrupt read.
// - Command write of 29h starts the 48-bit extended block-interrupt read.
// - Reads one or more sectors from media, then hands them to the host.
// - Sector data leaves through the data register one 16-bit word at a time.
// - Interrupt raised once per block of sectors, not per sector.
// - Otherwise behaves like the plain sector read: busy, data request, completion.
// - On completion or error the address is returned in the task file.
// - Extended count is previous:current bytes; zero means 65,536 sectors.
// - Extended address: current bytes give bits 23:0, previous give 47:24.
// - High-byte select picks upper or lower three address bytes on readback.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module block_read_cmd (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [block_read_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [block_read_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire block_read_pkg::media_beat_t media_beat,
  input wire logic media_valid,
  output logic media_ready,
  output logic media_req,
  output logic [47:0] media_lba,
  output logic irq
);
  import block_read_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic aw_v_q, aw_v_d, w_v_q, w_v_d, b_v_q, b_v_d;
  logic [5:0] aw_a_q, aw_a_d;
  logic [31:0] w_d_q, w_d_d;
  logic w_s_q, w_s_d;
  logic [1:0] b_r_q, b_r_d;
  logic ar_v_q, ar_v_d, r_v_q, r_v_d;
  logic [5:0] ar_a_q, ar_a_d;
  logic [31:0] r_d_q, r_d_d;
  logic [1:0] r_r_q, r_r_d;
  logic wr_go, rd_go, rd_wait, pop, wr_hit, rd_hit;
  logic [7:0] rd_byte;
  tf_byte_t seccnt_q, seccnt_d, secnum_q, secnum_d;
  tf_byte_t cyllo_q, cyllo_d, cylhi_q, cylhi_d;
  logic [7:0] devhead_q, devhead_d, blksize_q, blksize_d;
  logic hob_q, hob_d;
  cmd_state_t state_q, state_d;
  logic ext_q, ext_d, errst_q, errst_d, word_v_q, word_v_d;
  logic [15:0] word_q, word_d;
  logic [47:0] lba_q, lba_d, start_lba;
  logic [7:0] err_q, err_d, status;
  logic [16:0] sec_total;
  logic cmd_wr, op_hit, start, abort, beat, res_ld;
  logic [47:0] res_lba;
  logic [IRQ_W-1:0] evt, irq_stat, irq_mask;
  logic sector_end, block_end, cmd_end;

  // Decode of the register map; unmapped words answer with a slave error.
  function automatic logic mapped(input logic [5:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFS_IRQ_MASK);
  endfunction

  // Pick the current or previous byte of a task-file register.
  function automatic logic [7:0] tf_rd(input tf_byte_t r, input logic high_byte_readback_select);
    tf_rd = high_byte_readback_select ? r.prev : r.cur;
  endfunction

  // A host write moves the current byte into the previous slot.
  function automatic tf_byte_t tf_wr(input tf_byte_t r, input logic [7:0] v);
    tf_wr = '{cur: v, prev: r.cur};
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_v_q;
  assign s_axi_wready = !w_v_q;
  assign s_axi_arready = !ar_v_q && !r_v_q;
  assign s_axi_bvalid = b_v_q;
  assign s_axi_bresp = b_r_q;
  assign s_axi_rvalid = r_v_q;
  assign s_axi_rdata = r_d_q;
  assign s_axi_rresp = r_r_q;
  assign wr_go = aw_v_q && w_v_q && !b_v_q;
  assign wr_hit = wr_go && w_s_q;
  // In S_XFER a data read waits for the next word rather than returning stale data.
  assign rd_wait = (ar_a_q == OFS_DATA) && (state_q == S_XFER) && !word_v_q;
  assign rd_go = ar_v_q && !r_v_q && !rd_wait;
  assign rd_hit = rd_go && (ar_a_q == OFS_DATA) && (state_q == S_XFER);
  assign pop = rd_hit;

  // Register read multiplexer.
  always_comb begin
    rd_byte = 8'h00;
    case (ar_a_q)
      OFS_ERR_FEAT: rd_byte = err_q;
      OFS_SECCNT: rd_byte = tf_rd(seccnt_q, hob_q);
      OFS_SECNUM: rd_byte = tf_rd(secnum_q, hob_q);
      OFS_CYLLO: rd_byte = tf_rd(cyllo_q, hob_q);
      OFS_CYLHI: rd_byte = tf_rd(cylhi_q, hob_q);
      OFS_DEVHEAD: rd_byte = devhead_q;
      OFS_STAT_CMD: rd_byte = status;
      OFS_DEVCTL: rd_byte = {hob_q, 7'h00};
      OFS_BLKSIZE: rd_byte = blksize_q;
      OFS_IRQ_STAT: rd_byte = {6'h00, irq_stat};
      OFS_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  // Address and data channels are held separately and joined when both are in.
  always_comb begin
    aw_v_d = aw_v_q;
    aw_a_d = aw_a_q;
    w_v_d = w_v_q;
    w_d_d = w_d_q;
    w_s_d = w_s_q;
    b_v_d = b_v_q && !s_axi_bready;
    b_r_d = b_r_q;
    ar_v_d = ar_v_q;
    ar_a_d = ar_a_q;
    r_v_d = r_v_q && !s_axi_rready;
    r_d_d = r_d_q;
    r_r_d = r_r_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_v_d = 1'b1;
      aw_a_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_v_d = 1'b1;
      w_d_d = s_axi_wdata;
      w_s_d = s_axi_wstrb[0];
    end
    if (wr_go) begin
      aw_v_d = 1'b0;
      w_v_d = 1'b0;
      b_v_d = 1'b1;
      b_r_d = mapped(aw_a_q) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ar_v_d = 1'b1;
      ar_a_d = s_axi_araddr;
    end
    if (rd_go) begin
      ar_v_d = 1'b0;
      r_v_d = 1'b1;
      r_r_d = mapped(ar_a_q) ? RESP_OKAY : RESP_SLVERR;
      r_d_d = (ar_a_q == OFS_DATA) ? {16'h0000, pop ? word_q : 16'h0000} : {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_v_q <= 1'b0;
      aw_a_q <= 6'h00;
      w_v_q <= 1'b0;
      w_d_q <= 32'h00000000;
      w_s_q <= 1'b0;
      b_v_q <= 1'b0;
      b_r_q <= RESP_OKAY;
      ar_v_q <= 1'b0;
      ar_a_q <= 6'h00;
      r_v_q <= 1'b0;
      r_d_q <= 32'h00000000;
      r_r_q <= RESP_OKAY;
    end else begin
      aw_v_q <= aw_v_d;
      aw_a_q <= aw_a_d;
      w_v_q <= w_v_d;
      w_d_q <= w_d_d;
      w_s_q <= w_s_d;
      b_v_q <= b_v_d;
      b_r_q <= b_r_d;
      ar_v_q <= ar_v_d;
      ar_a_q <= ar_a_d;
      r_v_q <= r_v_d;
      r_d_q <= r_d_d;
      r_r_q <= r_r_d;
    end
  end

  // ----------------------------------------------------------------------
  // Task file
  // ----------------------------------------------------------------------
  // Host writes land only while idle; a finished command loads its address.
  always_comb begin
    seccnt_d = seccnt_q;
    secnum_d = secnum_q;
    cyllo_d = cyllo_q;
    cylhi_d = cylhi_q;
    devhead_d = devhead_q;
    blksize_d = blksize_q;
    hob_d = hob_q;
    if (res_ld) begin
      secnum_d = '{cur: res_lba[7:0], prev: res_lba[31:24]};
      cyllo_d = '{cur: res_lba[15:8], prev: res_lba[39:32]};
      cylhi_d = '{cur: res_lba[23:16], prev: res_lba[47:40]};
      if (!ext_q) begin
        devhead_d = {devhead_q[7:4], res_lba[27:24]};
      end
    end else if (wr_hit && state_q == S_IDLE) begin
      case (aw_a_q)
        OFS_SECCNT: seccnt_d = tf_wr(seccnt_q, w_d_q[7:0]);
        OFS_SECNUM: secnum_d = tf_wr(secnum_q, w_d_q[7:0]);
        OFS_CYLLO: cyllo_d = tf_wr(cyllo_q, w_d_q[7:0]);
        OFS_CYLHI: cylhi_d = tf_wr(cylhi_q, w_d_q[7:0]);
        OFS_DEVHEAD: devhead_d = w_d_q[7:0];
        OFS_DEVCTL: hob_d = w_d_q[HOB_BIT];
        OFS_BLKSIZE: blksize_d = w_d_q[7:0];
        default: hob_d = hob_q;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seccnt_q <= '0;
      secnum_q <= '0;
      cyllo_q <= '0;
      cylhi_q <= '0;
      devhead_q <= DEVHEAD_RST;
      blksize_q <= BLKSIZE_RST;
      hob_q <= 1'b0;
    end else begin
      seccnt_q <= seccnt_d;
      secnum_q <= secnum_d;
      cyllo_q <= cyllo_d;
      cylhi_q <= cylhi_d;
      devhead_q <= devhead_d;
      blksize_q <= blksize_d;
      hob_q <= hob_d;
    end
  end

  // ----------------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------------
  assign cmd_wr = wr_hit && (aw_a_q == OFS_STAT_CMD) && (state_q == S_IDLE);
  assign op_hit = (w_d_q[7:0] == OP_READ_MULT) || (w_d_q[7:0] == OP_READ_MULT_EXT);
  assign start = cmd_wr && op_hit && (blksize_q != 8'h00);
  assign abort = cmd_wr && op_hit && (blksize_q == 8'h00);
  // Zero counts expand to the full range of each form.
  assign sec_total = (w_d_q[7:0] == OP_READ_MULT_EXT)
    ? (({seccnt_q.prev, seccnt_q.cur} == 16'h0000) ? CNT_EXT_ZERO : {1'b0, seccnt_q.prev, seccnt_q.cur})
    : ((seccnt_q.cur == 8'h00) ? CNT_STD_ZERO : {9'h000, seccnt_q.cur});
  assign start_lba = (w_d_q[7:0] == OP_READ_MULT_EXT)
    ? {cylhi_q.prev, cyllo_q.prev, secnum_q.prev, cylhi_q.cur, cyllo_q.cur, secnum_q.cur}
    : {20'h00000, devhead_q[3:0], cylhi_q.cur, cyllo_q.cur, secnum_q.cur};
  // One word slot only: the media side stalls until the host drains it.
  assign media_ready = (state_q != S_IDLE) && !word_v_q;
  assign media_req = (state_q != S_IDLE);
  assign media_lba = lba_q;
  assign beat = media_valid && media_ready;
  // Busy while fetching, data request while the host drains a block.
  assign status = {state_q == S_FETCH, 1'b1, 1'b0, 1'b1, state_q == S_XFER, 1'b0, 1'b0, errst_q};

  always_comb begin
    state_d = state_q;
    ext_d = ext_q;
    lba_d = lba_q;
    word_d = word_q;
    word_v_d = word_v_q;
    err_d = err_q;
    errst_d = errst_q;
    evt = '0;
    res_ld = 1'b0;
    res_lba = lba_q;
    case (state_q)
      S_IDLE: begin
        if (start) begin
          state_d = S_FETCH;
          ext_d = (w_d_q[7:0] == OP_READ_MULT_EXT);
          lba_d = start_lba;
          err_d = 8'h00;
          errst_d = 1'b0;
        end else if (abort) begin
          err_d = 8'h00;
          err_d[ER_ABT] = 1'b1;
          errst_d = 1'b1;
          evt[IRQ_ERROR] = 1'b1;
        end
      end
      S_FETCH, S_XFER: begin
        if (beat && media_beat.err) begin
          state_d = S_IDLE;
          word_v_d = 1'b0;
          err_d = 8'h00;
          err_d[ER_UNC] = media_beat.uncorrectable_data_flag;
          err_d[ER_IDN] = !media_beat.uncorrectable_data_flag;
          errst_d = 1'b1;
          evt[IRQ_ERROR] = 1'b1;
          res_ld = 1'b1;
        end else if (beat) begin
          word_d = media_beat.word;
          word_v_d = 1'b1;
          if (state_q == S_FETCH) begin
            state_d = S_XFER;
            evt[IRQ_BLOCK] = 1'b1;
          end
        end else if (pop) begin
          word_v_d = 1'b0;
          if (sector_end) begin
            lba_d = lba_q + 48'h000000000001;
          end
          if (cmd_end) begin
            state_d = S_IDLE;
            res_ld = 1'b1;
          end else if (block_end) begin
            state_d = S_FETCH;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      ext_q <= 1'b0;
      lba_q <= 48'h000000000000;
      word_q <= 16'h0000;
      word_v_q <= 1'b0;
      err_q <= 8'h00;
      errst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ext_q <= ext_d;
      lba_q <= lba_d;
      word_q <= word_d;
      word_v_q <= word_v_d;
      err_q <= err_d;
      errst_q <= errst_d;
    end
  end

  sector_tracker #(.WORDS(WORDS_PER_SECTOR)) u_track (
    .clock(clock),
    .rst_n(rst_n),
    .start(start),
    .sec_total(sec_total),
    .blk_size(blksize_q),
    .adv(pop),
    .sector_end(sector_end),
    .block_end(block_end),
    .cmd_end(cmd_end)
  );

  event_irq #(.W(IRQ_W)) u_irq (
    .clock(clock),
    .rst_n(rst_n),
    .evt(evt),
    .clr_we(wr_hit && aw_a_q == OFS_IRQ_STAT),
    .mask_we(wr_hit && aw_a_q == OFS_IRQ_MASK),
    .wr_bits(w_d_q[IRQ_W-1:0]),
    .stat_q(irq_stat),
    .mask_q(irq_mask),
    .irq(irq)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_c4_starts_std: assert property (start && w_d_q[7:0] == OP_READ_MULT |=> state_q == S_FETCH && !ext_q)
    else $error("C4h did not start a 28-bit read");
  a_29_starts_ext: assert property (start && w_d_q[7:0] == OP_READ_MULT_EXT |=> state_q == S_FETCH && ext_q)
    else $error("29h did not start an extended read");
  a_media_from_start: assert property (start |=> media_req && media_lba == $past(start_lba))
    else $error("media request not raised at the start address");
  a_data_word_width: assert property (s_axi_rvalid && $past(pop) |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("data word wider than 16 bits");
  a_block_irq_once: assert property (pop && !block_end |=> !evt[IRQ_BLOCK] && state_q == S_XFER)
    else $error("interrupt or state change inside a block");
  a_block_irq_sets: assert property (evt[IRQ_BLOCK] |=> irq_stat[IRQ_BLOCK])
    else $error("block event not latched");
  a_zero_blk_aborts: assert property (abort |=> err_q[ER_ABT] && errst_q && state_q == S_IDLE)
    else $error("zero block size not aborted");
  a_bsy_drq_apart: assert property (!(status[7] && status[3]))
    else $error("busy and data request together");
  a_result_addr: assert property (pop && cmd_end |=> secnum_q.cur == $past(lba_q[7:0]))
    else $error("completion address not returned");
  a_ext_zero_count: assert property (start && ext_d && seccnt_q == '0 |-> sec_total == CNT_EXT_ZERO)
    else $error("extended zero count not 65536");
  a_ext_upper_lba: assert property (start && ext_d |=> lba_q[47:24] == $past({cylhi_q.prev, cyllo_q.prev, secnum_q.prev}))
    else $error("extended upper address wrong");
  a_status_zero_bits: assert property (status[5] == 1'b0 && status[2] == 1'b0 && status[6] && err_q[7] == 1'b0)
    else $error("reserved status or error bit set");

  c_block_read: cover property (state_q == S_FETCH ##1 state_q == S_XFER);
  c_cmd_done: cover property (pop && cmd_end);
  c_media_error: cover property (beat && media_beat.err);
  c_abort: cover property (abort);
endmodule
`default_nettype wire

// ==== verilog/event_irq.sv ====
// Sticky event status with write-one-to-clear, mask and one level interrupt.
// Assumes events and clear strobes are on the same clock.
`timescale 1ns/10ps
`default_nettype none
module event_irq #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] evt,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [W-1:0] wr_bits,
  output logic [W-1:0] stat_q,
  output logic [W-1:0] mask_q,
  output logic irq
);
  import block_read_pkg::*;

  if (W < 1) begin : g_bad_w
    $error("event_irq: W must be at least 1");
  end

  logic [W-1:0] stat_d, mask_d;

  // A new event wins over a clear in the same cycle, so none is lost.
  always_comb begin
    stat_d = (stat_q & ~(clr_we ? wr_bits : '0)) | evt;
    mask_d = mask_we ? wr_bits : mask_q;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat_q <= '0;
      mask_q <= W'(IRQ_MASK_RST);
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  assign irq = |(stat_q & mask_q);
endmodule
`default_nettype wire

// ==== verilog/sector_tracker.sv ====
// Word, sector and block counters for one multi-sector read.
// Assumes start and adv never arrive in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module sector_tracker #(
  parameter int WORDS = 256
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [16:0] sec_total,
  input wire logic [7:0] blk_size,
  input wire logic adv,
  output logic sector_end,
  output logic block_end,
  output logic cmd_end
);
  import block_read_pkg::*;

  if (WORDS < 2 || WORDS > 256) begin : g_bad_words
    $error("sector_tracker: WORDS must lie in 2..256");
  end

  logic [7:0] word_q, word_d;
  logic [16:0] sec_q, sec_d;
  logic [7:0] blk_q, blk_d;
  logic [7:0] blk_size_q, blk_size_d;

  // Flags describe the word currently offered to the host.
  assign sector_end = (word_q == 8'(WORDS - 1));
  assign cmd_end = sector_end && (sec_q == 17'h00001);
  assign block_end = sector_end && ((blk_q == 8'h01) || cmd_end);

  // Count down sectors and sectors left in the block; reload per block.
  always_comb begin
    word_d = word_q;
    sec_d = sec_q;
    blk_d = blk_q;
    blk_size_d = blk_size_q;
    if (start) begin
      word_d = 8'h00;
      sec_d = sec_total;
      blk_d = blk_size;
      blk_size_d = blk_size;
    end else if (adv) begin
      word_d = sector_end ? 8'h00 : word_q + 8'h01;
      if (sector_end) begin
        sec_d = sec_q - 17'h00001;
        blk_d = (blk_q == 8'h01) ? blk_size_q : blk_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      word_q <= 8'h00;
      sec_q <= 17'h00000;
      blk_q <= 8'h00;
      blk_size_q <= 8'h00;
    end else begin
      word_q <= word_d;
      sec_q <= sec_d;
      blk_q <= blk_d;
      blk_size_q <= blk_size_d;
    end
  end
endmodule
`default_nettype wire
